// ===== include/cgfc_pkg.sv
/*
 * Shared constants and carriers for the gateway FIFO interrupt and
 * classical/FD format conversion block: register map, field positions,
 * reset values and the frame and bus request structs.
 * Assumes a single peripheral clock and a simple strobe register port.
 */
package cgfc_pkg;

	// Register port widths.
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// Upper bounds that the register map leaves room for.
	localparam int MAX_FIFO = 8;
	localparam int MAX_CH   = 32;

	// Register byte offsets; per-FIFO registers take one word each.
	localparam logic [7:0] GLOBAL_CTRL_OFF  = 8'h00;
	localparam logic [7:0] GLOBAL_ERR_OFF   = 8'h04;
	localparam logic [7:0] FD_CONFIG_OFF    = 8'h08;
	localparam logic [7:0] HIST_STATUS_OFF  = 8'h0C;
	localparam logic [7:0] FIFO_CONFIG_BASE = 8'h20;
	localparam logic [7:0] FIFO_STATUS_BASE = 8'h40;

	// Field positions in global_control_reg.
	localparam int GCTL_MSG_LOST_IE = 0;
	localparam int GCTL_HIST_OVF_IE = 1;
	localparam int GCTL_DLC_ERR_IE  = 2;
	// Field positions in global_error_flags_reg.
	localparam int GERR_MSG_LOST = 0;
	localparam int GERR_HIST_OVF = 1;
	localparam int GERR_DLC_ERR  = 2;
	// Field positions in fd_config_reg.
	localparam int FD_CONFIG_REG_CONV_EN = 0;
	localparam int FD_CONFIG_REG_FD_SEL  = 1;
	localparam int FD_CONFIG_REG_BRS_SEL = 2;
	// Field positions in fifo_config_reg and fifo_status_reg.
	localparam int FCFG_TX_IE    = 0;
	localparam int FCFG_COND_SEL = 1;
	localparam int FSTS_TX_FLAG  = 0;
	localparam int FSTS_LOST     = 1;
	localparam int FSTS_EMPTY    = 2;

	// Reset values of the global control and FD configuration fields.
	localparam logic [2:0] GCTRL_RST = 3'h0;
	localparam logic [2:0] FD_CONFIG_REG_RST = 3'h0;

	// Length codes used by the FD conversion.
	localparam logic [3:0] DLC_FD_MIN      = 4'h9;
	localparam logic [3:0] DLC_CLASSIC_MAX = 4'h8;

	// A routed frame header.
	typedef struct packed {
		logic [28:0] id;
		logic        ide;
		logic        fdf;
		logic        brs;
		logic [3:0]  dlc;
	} cgfc_frame_s;

	// One register port request.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              wr;
		logic              rd;
	} cgfc_bus_req_s;

endpackage

// ===== rtl/cgfc_gateway.sv
/*
 * Gateway FIFO transmit interrupt, global error interrupt and the
 * classical/FD format rewrite of routed frames, with its registers.
 * Assumes all event inputs and the frame stream come from logic on the
 * same clock, so none of them is synchronised here.
 * Reset is asynchronous and active low; the register port never stalls.
 */
// Strobed register access and the register offsets are this design's own decisions.
`timescale 1ns/100ps

//Contract
//RULE1: Condition select 1 sets the FIFO transmit flag after every message.
//RULE2: Condition select 0 sets the flag only when transmission empties FIFO.
//RULE3: Transmit flag holds until software writes zero to it.
//RULE4: Enabled message loss in any FIFO raises the global error interrupt.
//RULE5: One module-wide enable gates message-lost reporting for all FIFOs.
//RULE6: Message-lost flag clears only on a zero write to its status register.
//RULE7: Global error interrupt ORs enabled loss, history overflow, DLC error.
//RULE8: Global overflow flag mirrors channel flags, cleared by clearing all.
//RULE9: Conversion enable bit switches on format rewrite of routed frames.
//RULE10: With conversion, FDF and BRS come from the two configuration bits.
//RULE11: With conversion and FD select, DLC of 9 or more becomes 8.
//RULE12: FD select 0 sends classical frames, 1 sends FD frames.
//RULE13: Software never routes remote or long FD frames while converting.
//RULE14: Handlers clear each serviced source flag in this block.
//RULE15: Handlers read the cleared flag back before returning.
//RULE16: Interrupt levels follow flag and enable, dropping a cycle after.
module cgfc_gateway #(
	parameter int NUM_FIFO = 3,
	parameter int NUM_CH   = 3
) (
	// Clock and reset.
	input  wire logic                      clk_sys_i,
	input  wire logic                      rst_n_i,
	// Register port.
	input  wire cgfc_pkg::cgfc_bus_req_s   bus_req_i,
	output logic [cgfc_pkg::DATA_W-1:0]    bus_rdata_o,
	// FIFO and channel events.
	input  wire logic [NUM_FIFO-1:0]       fifo_tx_done_i,
	input  wire logic [NUM_FIFO-1:0]       fifo_empty_i,
	input  wire logic [NUM_FIFO-1:0]       fifo_msg_lost_i,
	input  wire logic [NUM_CH-1:0]         hist_ovf_i,
	input  wire logic                      dlc_err_i,
	// Routed frame stream.
	input  wire logic                      gw_in_valid_i,
	input  wire cgfc_pkg::cgfc_frame_s     gw_in_frame_i,
	output logic                           gw_out_valid_o,
	output cgfc_pkg::cgfc_frame_s          gw_out_frame_o,
	// Interrupts.
	output logic [NUM_FIFO-1:0]            fifo_tx_irq_o,
	output logic                           global_err_irq_o
);

	// All state of the block.
	typedef struct packed {
		logic [2:0]                  gctrl;
		logic [2:0]                  fd_config_reg;
		logic                        dlc_err;
		logic [NUM_CH-1:0]           hist;
		logic [NUM_FIFO-1:0]         tx_ie;
		logic [NUM_FIFO-1:0]         cond_sel;
		logic [NUM_FIFO-1:0]         tx_flag;
		logic [NUM_FIFO-1:0]         lost;
		logic [NUM_FIFO-1:0]         tx_irq;
		logic                        err_irq;
		logic [cgfc_pkg::DATA_W-1:0] rdata;
		logic                        out_valid;
		cgfc_pkg::cgfc_frame_s       out_frame;
	} cgfc_state_s;

	cgfc_state_s                 st_q;
	cgfc_state_s                 st_d;
	logic [cgfc_pkg::DATA_W-1:0] rd_mux;
	logic [NUM_FIFO-1:0]         cfg_wr_hit;
	logic [NUM_FIFO-1:0]         sts_wr_hit;
	logic                        hist_wr_hit;
	logic                        gerr_wr_hit;

	// Byte address of the word for FIFO idx in a per-FIFO bank.
	function automatic logic [7:0] slot(input logic [7:0] base,
	                                    input int idx);
		slot = 8'(int'(base) + idx * 4);
	endfunction

	// Write-zero-to-clear flag; a new event in the same cycle wins.
	// Letting the set win means an event that lands on the clearing write
	// is never lost; software still sees it when it reads the flag back.
	function automatic logic w0c(input logic cur, input logic set,
	                             input logic hit, input logic wbit);
		w0c = set | (cur & ~(hit & ~wbit));
	endfunction

	// Format rewrite of one routed frame.
	// Remote and long FD frames are not filtered here; software keeps them
	// off the route while the rewrite is on.
	function automatic cgfc_pkg::cgfc_frame_s convert(
		input cgfc_pkg::cgfc_frame_s f, input logic [2:0] cfg);
		convert = f;
		if (cfg[cgfc_pkg::FD_CONFIG_REG_CONV_EN]) begin // see RULE9
			convert.fdf = cfg[cgfc_pkg::FD_CONFIG_REG_FD_SEL]; // see RULE10 RULE12
			convert.brs = cfg[cgfc_pkg::FD_CONFIG_REG_BRS_SEL]; // see RULE10
			// Classical lengths above 8 bytes cannot map onto FD codes.
			if (cfg[cgfc_pkg::FD_CONFIG_REG_FD_SEL] &&
			    f.dlc >= cgfc_pkg::DLC_FD_MIN) begin // see RULE11
				convert.dlc = cgfc_pkg::DLC_CLASSIC_MAX;
			end
		end
	endfunction

	// Next-state logic: register port, flags, interrupts and frame path.
	always_comb begin
		st_d        = st_q;
		rd_mux      = '0;
		cfg_wr_hit  = '0;
		sts_wr_hit  = '0;
		hist_wr_hit = bus_req_i.wr &&
		              bus_req_i.addr == cgfc_pkg::HIST_STATUS_OFF;
		gerr_wr_hit = bus_req_i.wr &&
		              bus_req_i.addr == cgfc_pkg::GLOBAL_ERR_OFF;

		// Read multiplexer; unmapped addresses read as zero.
		if (bus_req_i.addr == cgfc_pkg::GLOBAL_CTRL_OFF) begin
			rd_mux[2:0] = st_q.gctrl;
		end else if (bus_req_i.addr == cgfc_pkg::GLOBAL_ERR_OFF) begin
			rd_mux[cgfc_pkg::GERR_MSG_LOST] = |st_q.lost;
			rd_mux[cgfc_pkg::GERR_HIST_OVF] = |st_q.hist; // see RULE8
			rd_mux[cgfc_pkg::GERR_DLC_ERR]  = st_q.dlc_err;
		end else if (bus_req_i.addr == cgfc_pkg::FD_CONFIG_OFF) begin
			rd_mux[2:0] = st_q.fd_config_reg;
		end else if (bus_req_i.addr == cgfc_pkg::HIST_STATUS_OFF) begin
			rd_mux[NUM_CH-1:0] = st_q.hist;
		end
		for (int k = 0; k < NUM_FIFO; k++) begin
			if (bus_req_i.addr == slot(cgfc_pkg::FIFO_CONFIG_BASE, k)) begin
				rd_mux[cgfc_pkg::FCFG_TX_IE]    = st_q.tx_ie[k];
				rd_mux[cgfc_pkg::FCFG_COND_SEL] = st_q.cond_sel[k];
			end else if (bus_req_i.addr ==
			             slot(cgfc_pkg::FIFO_STATUS_BASE, k)) begin
				rd_mux[cgfc_pkg::FSTS_TX_FLAG] = st_q.tx_flag[k];
				rd_mux[cgfc_pkg::FSTS_LOST]    = st_q.lost[k];
				rd_mux[cgfc_pkg::FSTS_EMPTY]   = fifo_empty_i[k];
			end
		end
		// Read data stand only in the cycle after the strobe.
		st_d.rdata = bus_req_i.rd ? rd_mux : '0;

		// Plain control registers.
		if (bus_req_i.wr && bus_req_i.addr == cgfc_pkg::GLOBAL_CTRL_OFF) begin
			st_d.gctrl = bus_req_i.wdata[2:0];
		end
		if (bus_req_i.wr && bus_req_i.addr == cgfc_pkg::FD_CONFIG_OFF) begin
			st_d.fd_config_reg = bus_req_i.wdata[2:0];
		end

		// Global sticky sources, each cleared by a zero write.
		st_d.dlc_err = w0c(st_q.dlc_err, dlc_err_i, gerr_wr_hit,
		                   bus_req_i.wdata[cgfc_pkg::GERR_DLC_ERR]);
		for (int c = 0; c < NUM_CH; c++) begin
			st_d.hist[c] = w0c(st_q.hist[c], hist_ovf_i[c], hist_wr_hit,
			                   bus_req_i.wdata[c]); // see RULE8
		end

		// Per-FIFO configuration and flags.
		for (int k = 0; k < NUM_FIFO; k++) begin
			cfg_wr_hit[k] = bus_req_i.wr &&
			    bus_req_i.addr == slot(cgfc_pkg::FIFO_CONFIG_BASE, k);
			sts_wr_hit[k] = bus_req_i.wr &&
			    bus_req_i.addr == slot(cgfc_pkg::FIFO_STATUS_BASE, k);
			if (cfg_wr_hit[k]) begin
				st_d.tx_ie[k]    = bus_req_i.wdata[cgfc_pkg::FCFG_TX_IE];
				st_d.cond_sel[k] = bus_req_i.wdata[cgfc_pkg::FCFG_COND_SEL];
			end
			// Empty is sampled with the completion, i.e. after it.
			st_d.tx_flag[k] = w0c(st_q.tx_flag[k],
			    fifo_tx_done_i[k] &&
			    (st_q.cond_sel[k] || fifo_empty_i[k]), // see RULE1 RULE2
			    sts_wr_hit[k],
			    bus_req_i.wdata[cgfc_pkg::FSTS_TX_FLAG]); // see RULE3
			st_d.lost[k] = w0c(st_q.lost[k], fifo_msg_lost_i[k],
			    sts_wr_hit[k],
			    bus_req_i.wdata[cgfc_pkg::FSTS_LOST]); // see RULE6
		end

		// Interrupt levels lag their flags by one register stage.
		// The extra stage keeps every output on a flip-flop at one cycle's cost.
		st_d.tx_irq  = st_q.tx_flag & st_q.tx_ie; // see RULE16
		st_d.err_irq =
		    (st_q.gctrl[cgfc_pkg::GCTL_MSG_LOST_IE] &&
		     |st_q.lost) || // see RULE4 RULE5
		    (st_q.gctrl[cgfc_pkg::GCTL_HIST_OVF_IE] && |st_q.hist) ||
		    (st_q.gctrl[cgfc_pkg::GCTL_DLC_ERR_IE] &&
		     st_q.dlc_err); // see RULE7

		// Frame path; the header is held when no frame arrives.
		st_d.out_valid = gw_in_valid_i;
		if (gw_in_valid_i) begin
			st_d.out_frame = convert(gw_in_frame_i, st_q.fd_config_reg);
		end
	end

	// State register. Reset only loads constants, so the asynchronous
	// branch never depends on a signal that may itself be in reset; the
	// control fields take their named reset values on top of the zeros.
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_q       <= '0;
			st_q.gctrl <= cgfc_pkg::GCTRL_RST;
			st_q.fd_config_reg <= cgfc_pkg::FD_CONFIG_REG_RST;
		end else begin
			st_q <= st_d;
		end
	end

	// Outputs straight from the state register.
	assign bus_rdata_o      = st_q.rdata;
	assign gw_out_valid_o   = st_q.out_valid;
	assign gw_out_frame_o   = st_q.out_frame;
	assign fifo_tx_irq_o    = st_q.tx_irq;
	assign global_err_irq_o = st_q.err_irq;

	// Checks run on the block clock and stay quiet during reset, so the
	// first sampled cycle after release already sees the cleared state.
	// Sampled-value functions then look back at reset values only.
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// Per-FIFO flag and interrupt checks.
	for (genvar k = 0; k < NUM_FIFO; k++) begin : g_fifo_chk
		tx_every_msg_a: assert property ( // see RULE1
			fifo_tx_done_i[k] && st_q.cond_sel[k] |=> st_q.tx_flag[k])
			else $error("transmit flag missed a message");
		tx_empty_only_a: assert property ( // see RULE2
			$rose(st_q.tx_flag[k]) |-> $past(fifo_tx_done_i[k] &&
			    (st_q.cond_sel[k] || fifo_empty_i[k])))
			else $error("transmit flag set without its condition");
		tx_flag_clear_a: assert property ( // see RULE3
			sts_wr_hit[k] && !fifo_tx_done_i[k] &&
			!bus_req_i.wdata[cgfc_pkg::FSTS_TX_FLAG] |=> !st_q.tx_flag[k])
			else $error("transmit flag not cleared by zero write");
		lost_clear_only_a: assert property ( // see RULE6
			$fell(st_q.lost[k]) |-> $past(sts_wr_hit[k] &&
			    !bus_req_i.wdata[cgfc_pkg::FSTS_LOST]))
			else $error("message-lost flag cleared without write");
		// The level follows flag and enable one cycle late, both ways.
		irq_level_a: assert property ( // see RULE16
			fifo_tx_irq_o[k] == $past(st_q.tx_flag[k] && st_q.tx_ie[k]))
			else $error("transmit interrupt level wrong");
		// Only a zero write may take the transmit flag down.
		tx_flag_hold_a: assert property ( // see RULE3
			$fell(st_q.tx_flag[k]) |-> $past(sts_wr_hit[k] &&
			    !bus_req_i.wdata[cgfc_pkg::FSTS_TX_FLAG]))
			else $error("transmit flag cleared without write");
		// A lost message must leave its sticky flag behind.
		lost_sets_a: assert property ( // see RULE6
			fifo_msg_lost_i[k] |=> st_q.lost[k])
			else $error("message-lost flag not set");
		// A disabled FIFO keeps its flag but never raises its line.
		tx_irq_gate_a: assert property ( // see RULE16
			!st_q.tx_ie[k] |=> !fifo_tx_irq_o[k])
			else $error("transmit interrupt raised while disabled");
	end

	// Per-channel history overflow flags are sticky until cleared.
	for (genvar c = 0; c < NUM_CH; c++) begin : g_hist_chk
		hist_sets_a: assert property ( // see RULE8
			hist_ovf_i[c] |=> st_q.hist[c])
			else $error("history overflow flag not set");
		hist_clear_a: assert property ( // see RULE8
			$fell(st_q.hist[c]) |-> $past(hist_wr_hit &&
			    !bus_req_i.wdata[c]))
			else $error("history overflow flag cleared without write");
	end

	lost_reports_a: assert property ( // see RULE4
		st_q.gctrl[cgfc_pkg::GCTL_MSG_LOST_IE] && |st_q.lost
		|=> global_err_irq_o)
		else $error("message loss not reported");
	lost_gate_a: assert property ( // see RULE5
		(st_q.gctrl == 3'h0) [*2] |-> !global_err_irq_o)
		else $error("error interrupt raised while all disabled");
	err_sources_a: assert property ( // see RULE7
		(st_q.gctrl[cgfc_pkg::GCTL_HIST_OVF_IE] && |st_q.hist) ||
		(st_q.gctrl[cgfc_pkg::GCTL_DLC_ERR_IE] && st_q.dlc_err)
		|=> global_err_irq_o)
		else $error("enabled error source not reported");
	hist_global_a: assert property ( // see RULE8
		bus_req_i.rd && bus_req_i.addr == cgfc_pkg::GLOBAL_ERR_OFF
		|=> bus_rdata_o[cgfc_pkg::GERR_HIST_OVF] == $past(|st_q.hist))
		else $error("global overflow flag does not mirror channels");
	conv_pass_a: assert property ( // see RULE9
		gw_in_valid_i && !st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_CONV_EN]
		|=> gw_out_valid_o && gw_out_frame_o == $past(gw_in_frame_i))
		else $error("frame altered with conversion off");
	conv_fmt_a: assert property ( // see RULE10 RULE12
		gw_in_valid_i && st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_CONV_EN] |=>
		gw_out_frame_o.fdf == $past(st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_FD_SEL]) &&
		gw_out_frame_o.brs == $past(st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_BRS_SEL]))
		else $error("converted format bits wrong");
	dlc_cap_a: assert property ( // see RULE11
		gw_in_valid_i && st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_CONV_EN] &&
		st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_FD_SEL] &&
		gw_in_frame_i.dlc >= cgfc_pkg::DLC_FD_MIN
		|=> gw_out_frame_o.dlc == cgfc_pkg::DLC_CLASSIC_MAX)
		else $error("length code not limited to eight");
	// Read data stand for one cycle only, so a stale word never lingers.
	rdata_idle_a: assert property (
		!bus_req_i.rd |=> bus_rdata_o == '0)
		else $error("read data outside the answer cycle");
	// Frames leave exactly one cycle after they arrive.
	frame_delay_a: assert property ( // see RULE9
		gw_out_valid_o == $past(gw_in_valid_i))
		else $error("frame valid not delayed by one cycle");
	// A length code error must leave its sticky flag behind.
	dlc_sets_a: assert property ( // see RULE7
		dlc_err_i |=> st_q.dlc_err)
		else $error("length code error flag not set");
	// With every enabled source quiet, the error line falls next cycle.
	err_drop_a: assert property ( // see RULE16
		!(st_q.gctrl[cgfc_pkg::GCTL_MSG_LOST_IE] && |st_q.lost) &&
		!(st_q.gctrl[cgfc_pkg::GCTL_HIST_OVF_IE] && |st_q.hist) &&
		!(st_q.gctrl[cgfc_pkg::GCTL_DLC_ERR_IE] && st_q.dlc_err)
		|=> !global_err_irq_o)
		else $error("error interrupt held after its sources cleared");

	// Main scenarios.
	tx_irq_seen_c: cover property (fifo_tx_done_i[0] ##2 fifo_tx_irq_o[0]);
	err_irq_seen_c: cover property ($rose(global_err_irq_o));
	dlc_capped_c: cover property (gw_out_valid_o &&
		gw_out_frame_o.fdf && gw_out_frame_o.dlc ==
		cgfc_pkg::DLC_CLASSIC_MAX);
	hist_cleared_c: cover property ($fell(|st_q.hist));
	conv_off_c: cover property (gw_out_valid_o &&
		!st_q.fd_config_reg[cgfc_pkg::FD_CONFIG_REG_CONV_EN]);

endmodule

// ===== bench/cgfc_fifo_model.sv
/*
 * Behavioural stand-in for the gateway FIFO storage next to the block.
 * Assumes the bench pulses load and send commands on the design clock.
 */
`timescale 1ns/100ps
module cgfc_fifo_model #(
	parameter int N     = 3,
	parameter int DEPTH = 2
) (
	// Clock and reset.
	input  wire logic         clk_sys_i,
	input  wire logic         rst_n_i,
	// Bench commands.
	input  wire logic [N-1:0] load_i,
	input  wire logic [N-1:0] send_i,
	// Events towards the gateway.
	output logic      [N-1:0] tx_done_o,
	output logic      [N-1:0] empty_o,
	output logic      [N-1:0] lost_o
);
	int cnt [N];

	// Empty is updated with the completion pulse, so the gateway sees the
	// state after the message left; a load into a full FIFO is flagged lost, but is still stored when a send lands in the same cycle.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		for (int k = 0; k < N; k++) begin
			if (!rst_n_i) begin
				cnt[k] = 0;
				tx_done_o[k] <= 1'b0;
				lost_o[k] <= 1'b0;
				empty_o[k] <= 1'b1;
			end else begin
				lost_o[k] <= load_i[k] && cnt[k] == DEPTH;
				tx_done_o[k] <= send_i[k] && cnt[k] > 0;
				if (send_i[k] && cnt[k] > 0) begin
					cnt[k] = cnt[k] - 1;
				end
				if (load_i[k] && cnt[k] < DEPTH) begin
					cnt[k] = cnt[k] + 1;
				end
				empty_o[k] <= cnt[k] == 0;
			end
		end
	end
endmodule

// ===== bench/can_gateway_fifo_fd_convert_test.sv
/*
 * Self-checking bench for the gateway interrupt and format rewrite block.
 * Assumes the FIFO model file is compiled first and the package is visible.
 */
`timescale 1ns/100ps
module can_gateway_fifo_fd_convert_test;
	// Clock, reset and bookkeeping.
	logic                  clk_sys_i = 1'b0;
	logic                  rst_n_i   = 1'b0;
	int                    num_errors = 0;
	int                    n_compared = 0;
	int                    seed       = 68426;
	int                    cyc        = 0;
	// Stimulus and responses.
	cgfc_pkg::cgfc_bus_req_s req      = '0;
	logic [31:0]           rdata;
	logic [2:0]            ld = '0;
	logic [2:0]            sd = '0;
	logic [2:0]            hist = '0;
	logic                  dlc_err = 1'b0;
	logic [2:0]            txd, emp, lost, tx_irq;
	logic                  err_irq, in_v = 1'b0, out_v;
	cgfc_pkg::cgfc_frame_s in_f = '0, out_f, f, prev;

	cgfc_fifo_model #(.N(3), .DEPTH(2)) model (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .load_i(ld), .send_i(sd), .tx_done_o(txd),
		.empty_o(emp), .lost_o(lost));
	cgfc_gateway #(.NUM_FIFO(3), .NUM_CH(3)) dut (.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i), .bus_req_i(req), .bus_rdata_o(rdata),
		.fifo_tx_done_i(txd), .fifo_empty_i(emp), .fifo_msg_lost_i(lost),
		.hist_ovf_i(hist), .dlc_err_i(dlc_err), .gw_in_valid_i(in_v),
		.gw_in_frame_i(in_f), .gw_out_valid_o(out_v),
		.gw_out_frame_o(out_f), .fifo_tx_irq_o(tx_irq),
		.global_err_irq_o(err_irq));

	// Clock and a cycle ceiling well above the few hundred cycles needed.
	always #50 clk_sys_i = ~clk_sys_i;
	always @(posedge clk_sys_i) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			complete_run();
		end
	end

	task automatic complete_run();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_frm(input logic [36:0] got, input logic [36:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t frame %h expected %h", $time, got, exp);
		end
	endtask

	// Bus master: one-cycle strobes launched right after an edge.
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_i);
		req.wr <= 1'b1;
		req.addr <= a;
		req.wdata <= d;
		@(posedge clk_sys_i);
		req.wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk_sys_i);
		req.rd <= 1'b1;
		req.addr <= a;
		@(posedge clk_sys_i);
		req.rd <= 1'b0;
		#1;
		chk(rdata, e);
	endtask

	// One command cycle to the FIFO model or the channel events, then
	// enough idle cycles for flags and interrupt levels to settle.
	task automatic ev(input logic [2:0] l, input logic [2:0] s,
		input logic [2:0] h, input logic d);
		@(posedge clk_sys_i);
		ld <= l;
		sd <= s;
		hist <= h;
		dlc_err <= d;
		@(posedge clk_sys_i);
		ld <= '0;
		sd <= '0;
		hist <= '0;
		dlc_err <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
	endtask

	function automatic cgfc_pkg::cgfc_frame_s conv(
		input cgfc_pkg::cgfc_frame_s x, input logic [2:0] c);
		conv = x;
		if (c[cgfc_pkg::FD_CONFIG_REG_CONV_EN]) begin
			conv.fdf = c[cgfc_pkg::FD_CONFIG_REG_FD_SEL];
			conv.brs = c[cgfc_pkg::FD_CONFIG_REG_BRS_SEL];
			if (conv.fdf && x.dlc >= 4'h9) begin
				conv.dlc = 4'h8;
			end
		end
	endfunction

	initial begin
		repeat (20) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd_chk(cgfc_pkg::GLOBAL_CTRL_OFF, 32'h0);
		rd_chk(8'hFC, 32'h0);
		// FIFO0 interrupts on every message, FIFO1 only on empty.
		wr(cgfc_pkg::FIFO_CONFIG_BASE, 32'h3);
		wr(cgfc_pkg::FIFO_CONFIG_BASE + 8'h04, 32'h1);
		ev(3'h3, 3'h0, 3'h0, 1'b0);
		ev(3'h3, 3'h3, 3'h0, 1'b0);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE, 32'h1);
		chk(32'(tx_irq), 32'h1);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE + 8'h04, 32'h0);
		ev(3'h0, 3'h3, 3'h0, 1'b0);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE + 8'h04, 32'h5);
		wr(cgfc_pkg::FIFO_STATUS_BASE, 32'h0);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE, 32'h4);
		chk(32'(tx_irq), 32'h2);
		wr(cgfc_pkg::FIFO_STATUS_BASE + 8'h04, 32'h0);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE + 8'h04, 32'h4);
		// Third load into FIFO2 overflows it while reporting is off.
		repeat (3) ev(3'h4, 3'h0, 3'h0, 1'b0);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE + 8'h08, 32'h2);
		chk(32'(err_irq), 32'h0);
		wr(cgfc_pkg::GLOBAL_CTRL_OFF, 32'h1);
		rd_chk(cgfc_pkg::GLOBAL_ERR_OFF, 32'h1);
		chk(32'(err_irq), 32'h1);
		wr(cgfc_pkg::FIFO_STATUS_BASE + 8'h08, 32'h2);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE + 8'h08, 32'h2);
		wr(cgfc_pkg::FIFO_STATUS_BASE + 8'h08, 32'h0);
		rd_chk(cgfc_pkg::FIFO_STATUS_BASE + 8'h08, 32'h0);
		chk(32'(err_irq), 32'h0);
		// History overflow on two channels, then a DLC error.
		wr(cgfc_pkg::GLOBAL_CTRL_OFF, 32'h6);
		ev(3'h0, 3'h0, 3'h5, 1'b0);
		rd_chk(cgfc_pkg::HIST_STATUS_OFF, 32'h5);
		chk(32'(err_irq), 32'h1);
		wr(cgfc_pkg::HIST_STATUS_OFF, 32'h1);
		rd_chk(cgfc_pkg::GLOBAL_ERR_OFF, 32'h2);
		wr(cgfc_pkg::HIST_STATUS_OFF, 32'h0);
		rd_chk(cgfc_pkg::GLOBAL_ERR_OFF, 32'h0);
		ev(3'h0, 3'h0, 3'h0, 1'b1);
		rd_chk(cgfc_pkg::GLOBAL_ERR_OFF, 32'h4);
		chk(32'(err_irq), 32'h1);
		wr(cgfc_pkg::GLOBAL_ERR_OFF, 32'h0);
		rd_chk(cgfc_pkg::GLOBAL_ERR_OFF, 32'h0);
		// Every conversion setting with back-to-back random frames.
		for (int c = 0; c < 8; c++) begin
			wr(cgfc_pkg::FD_CONFIG_OFF, 32'(c));
			rd_chk(cgfc_pkg::FD_CONFIG_OFF, 32'(c));
			for (int i = 0; i < 8; i++) begin
				@(posedge clk_sys_i);
				f = cgfc_pkg::cgfc_frame_s'(36'({$random(seed), $random(seed)}));
				if (i < 2) begin
					f.fdf = 1'b0;
					f.dlc = 4'h9 - 4'(i);
				end
				// Long FD frames are kept off the route while converting.
				if (c[0] && f.fdf && f.dlc > 4'h8) begin
					f.dlc = 4'h8;
				end
				in_v <= (i < 7);
				in_f <= f;
				#1;
				if (i > 0) begin
					chk_frm({out_v, out_f}, {1'b1, conv(prev, 3'(c))});
				end
				prev = f;
			end
			@(posedge clk_sys_i);
			#1;
			chk(32'(out_v), 32'h0);
		end
		complete_run();
	end
endmodule
